// >>> core/rtc_calendar_params.svh
// Offsets, field positions, reset values and timing counts of the clock calendar unit
`ifndef RTC_CALENDAR_PARAMS_SVH
`define RTC_CALENDAR_PARAMS_SVH

// Register byte addresses on the 16-bit register port
`define OFS_CAL_CONFIG 4'h0
`define OFS_PAD_CONFIG 4'h2
`define OFS_ALARM_CFG 4'h4
`define OFS_TIME_WIN 4'h6
`define OFS_ALARM_WIN 4'h8

// Calibration and configuration fields
`define CFG_MODULE_ON 15
`define CFG_UNLOCK 13
`define CFG_SYNC 12
`define CFG_HALF 11
`define CFG_DRIVE_ON 10
`define CFG_PTR_HI 9
`define CFG_PTR_LO 8
`define CFG_CAL_HI 7

// Pad configuration fields
`define PAD_SRC_SEL 1
`define PAD_BUF_SEL 0

// Alarm configuration fields
`define ALM_ON 15
`define ALM_CHIME 14
`define ALM_MASK_HI 13
`define ALM_MASK_LO 10
`define ALM_PTR_HI 9
`define ALM_PTR_LO 8
`define ALM_RPT_HI 7

// Reset values
`define CAL_CONFIG_RESET 16'h0000
`define ALARM_CFG_RESET 16'h0000
`define PAD_RESET 2'h0
`define RPT_EMPTY 8'h00
`define RPT_FULL 8'hFF

// Value field masks, unimplemented bits read as zero
`define MASK_SEC 8'h7F
`define MASK_MIN 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_WDAY 8'h07
`define MASK_DAY 8'h3F
`define MASK_MONTH 8'h1F
`define MASK_YEAR 8'hFF

// Rollover limits in BCD
`define BCD_59 8'h59
`define BCD_23 8'h23
`define BCD_99 8'h99
`define BCD_12 8'h12
`define BCD_01 8'h01
`define BCD_00 8'h00
`define WDAY_LAST 8'h06
`define FEB 8'h02

// Secondary oscillator pulses per second and per half second
`define PRESC_LAST 17'h07FFF
`define PRESC_HALF 17'h04000
`define PRESC_SYNC 17'h07F00
`define CAL_STEP_SHIFT 2

`endif

// >>> core/rtc_calendar_pkg.sv
// Types shared by the clock calendar unit
package rtc_calendar_pkg;
   // Window pointer selection, names from the low byte of each pair
   typedef enum logic [1:0] {
      WIN_SEC_MIN = 2'b00,
      WIN_HOUR_WDAY = 2'b01,
      WIN_DAY_MONTH = 2'b10,
      WIN_YEAR = 2'b11
   } window_sel_t;

   // Alarm interval codes
   typedef enum logic [3:0] {
      INT_HALF_SEC = 4'h0,
      INT_SEC = 4'h1,
      INT_TEN_SEC = 4'h2,
      INT_MINUTE = 4'h3,
      INT_TEN_MIN = 4'h4,
      INT_HOUR = 4'h5,
      INT_DAY = 4'h6,
      INT_WEEK = 4'h7,
      INT_MONTH = 4'h8,
      INT_YEAR = 4'h9
   } alarm_interval_t;
endpackage

// >>> core/rtc_calendar_alarm_regs.sv
// Clock calendar unit: configuration, calibration, BCD time keeping and alarm
//
// What this block does
// - Positive calibration code adds four pulses per step, up to 508 per minute.
// - Negative codes subtract four per step; all ones -4, most negative -512.
// - Calibration code zero makes no adjustment at all.
// - Calibration and configuration register resets only on power-on reset.
// - Module on bit is writable only while value write unlock is set.
// - Half second flag is read-only; cleared by write to seconds byte.
// - Pad bit 1 picks seconds clock (1) or alarm pulse (0) for the pin.
// - Clock pin is driven only while the pin drive bit is set.
// - Alarm on clears after an event with repeat count 00h and chime off.
// - With chime the repeat count wraps 00h to FFh, else stops at 00h.
// - Interval code 0000 to 1001: half second up to once a year.
// - Yearly alarm on February 29th fires only in leap years.
// - Alarm window pointer picks alarm pair; code 11 is unimplemented.
// - Alarm pointer decrements on any alarm window read or high byte write, stops at 00.
// - Repeat count decrements on every alarm event, holding up to 255.
// - Year holds two BCD digits in its low byte; high byte reads zero.
// - Month-day holds month tens bit 12, ones 11-8, day tens 5-4, ones 3-0.
// - Weekday-hour holds weekday 10-8, hour tens 5-4, hour ones 3-0.
// - Minute-second holds minute tens 14-12, ones 11-8, second tens 6-4, ones 3-0.
// - Year, month-day and weekday-hour writes need value write unlock.
// - Time window pointer picks value pair, 11 selects the year.
// - Any read of a value window decrements its pointer; writes on high byte.
// - Time value window is locked while value write unlock is clear.
// - Alarm fires when the digits chosen by the interval match the clock.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "rtc_calendar_params.svh"

module rtc_calendar_alarm_regs (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic por,
   input wire logic sosc_tick,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [1:0] reg_byte_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic clock_pin_out,
   output logic clock_pin_oe,
   output logic alarm_event,
   output logic parallel_port_buffer_select
);
   import rtc_calendar_pkg::*;

   // Last day of a month in BCD, leap years from the year digits (2000-2099)
   function automatic logic [7:0] month_last(input logic [7:0] mth, input logic [7:0] yr);
      logic leap;
      leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
             (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
      if (mth == `FEB) begin
         month_last = leap ? 8'h29 : 8'h28;
      end else if (mth == 8'h04 || mth == 8'h06 || mth == 8'h09 || mth == 8'h11) begin
         month_last = 8'h30;
      end else begin
         month_last = 8'h31;
      end
   endfunction

   // BCD step: wrap to first after last, otherwise count with decimal carry
   function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
      if (v == last) begin
         bcd_step = first;
      end else if (v[3:0] == 4'h9) begin
         bcd_step = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_step = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   logic [15:0] cfg_reg;
   logic [1:0] pad_reg;
   logic [15:0] alm_cfg_reg;
   logic signed [16:0] presc_reg;
   logic [7:0] sec_reg, min_reg, hr_reg, wd_reg, day_reg, mth_reg, yr_reg;
   logic [7:0] asec_reg, amin_reg, ahr_reg, awd_reg, aday_reg, amth_reg;
   logic alm_pulse_reg;
   logic [15:0] rdata_next;

   logic module_on, value_write_unlock, half_second_flag, clock_pin_drive_on;
   logic pin_source_select, alarm_on, chime;
   logic [1:0] time_window_pointer, alarm_window_pointer;
   logic [3:0] alarm_interval_code;
   logic [7:0] alarm_repeat_count;
   logic signed [7:0] cal_code;
   logic signed [16:0] cal_offset;

   assign module_on = cfg_reg[`CFG_MODULE_ON];
   assign value_write_unlock = cfg_reg[`CFG_UNLOCK];
   assign clock_pin_drive_on = cfg_reg[`CFG_DRIVE_ON];
   assign time_window_pointer = cfg_reg[`CFG_PTR_HI:`CFG_PTR_LO];
   assign cal_code = cfg_reg[`CFG_CAL_HI:0];
   assign pin_source_select = pad_reg[`PAD_SRC_SEL];
   assign parallel_port_buffer_select = pad_reg[`PAD_BUF_SEL];
   assign alarm_on = alm_cfg_reg[`ALM_ON];
   assign chime = alm_cfg_reg[`ALM_CHIME];
   assign alarm_interval_code = alm_cfg_reg[`ALM_MASK_HI:`ALM_MASK_LO];
   assign alarm_window_pointer = alm_cfg_reg[`ALM_PTR_HI:`ALM_PTR_LO];
   assign alarm_repeat_count = alm_cfg_reg[`ALM_RPT_HI:0];

   // Signed code times four; zero code gives zero offset
   assign cal_offset = 17'(cal_code) <<< `CAL_STEP_SHIFT;

   // Bus access decode
   logic wr_cfg, wr_pad, wr_alm_cfg, wr_time, wr_alarm, rd_time, rd_alarm;
   logic wr_hi, wr_lo, time_wr_ok;
   assign wr_hi = reg_wr && reg_byte_en[1];
   assign wr_lo = reg_wr && reg_byte_en[0];
   assign wr_cfg = reg_wr && reg_addr == `OFS_CAL_CONFIG;
   assign wr_pad = reg_wr && reg_addr == `OFS_PAD_CONFIG;
   assign wr_alm_cfg = reg_wr && reg_addr == `OFS_ALARM_CFG;
   assign wr_time = reg_wr && reg_addr == `OFS_TIME_WIN;
   assign wr_alarm = reg_wr && reg_addr == `OFS_ALARM_WIN;
   assign rd_time = reg_rd && reg_addr == `OFS_TIME_WIN;
   assign rd_alarm = reg_rd && reg_addr == `OFS_ALARM_WIN;
   assign time_wr_ok = wr_time && value_write_unlock;

   // Prescaler events: the second ends at the last count
   logic run_tick, sec_tick, half_tick, min_end, hr_end, day_end, mth_end, yr_end;
   logic sec_lo_write;
   assign run_tick = module_on && sosc_tick;
   assign sec_tick = run_tick && presc_reg == `PRESC_LAST;
   assign half_tick = sec_tick || (run_tick && presc_reg == `PRESC_HALF - 17'sd1);
   assign min_end = sec_tick && sec_reg == `BCD_59;
   assign hr_end = min_end && min_reg == `BCD_59;
   assign day_end = hr_end && hr_reg == `BCD_23;
   assign mth_end = day_end && day_reg == month_last(mth_reg, yr_reg);
   assign yr_end = mth_end && mth_reg == `BCD_12;
   assign half_second_flag = presc_reg >= $signed(`PRESC_HALF); // Signed: negative trim is first half
   assign sec_lo_write = time_wr_ok && wr_lo && time_window_pointer == WIN_SEC_MIN;

   // Prescaler; a new minute starts ahead or behind by the calibration offset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         presc_reg <= '0;
      end else if (sec_lo_write) begin
         presc_reg <= '0;
      end else if (min_end) begin
         presc_reg <= cal_offset;
      end else if (sec_tick) begin
         presc_reg <= '0;
      end else if (run_tick) begin
         presc_reg <= presc_reg + 17'sd1;
      end
   end

   // Configuration only answers to power-on reset, so a soft reset keeps the trim
   always_ff @(posedge ref_clk) begin
      if (por) begin
         cfg_reg <= `CAL_CONFIG_RESET;
      end else begin
         if (wr_cfg && wr_hi) begin
            if (value_write_unlock) begin
               cfg_reg[`CFG_MODULE_ON] <= reg_wdata[`CFG_MODULE_ON];
            end
            cfg_reg[`CFG_UNLOCK] <= reg_wdata[`CFG_UNLOCK];
            cfg_reg[`CFG_DRIVE_ON] <= reg_wdata[`CFG_DRIVE_ON];
            cfg_reg[`CFG_PTR_HI:`CFG_PTR_LO] <= reg_wdata[`CFG_PTR_HI:`CFG_PTR_LO];
         end else if ((rd_time || (wr_time && wr_hi)) && time_window_pointer != 2'b00) begin
            cfg_reg[`CFG_PTR_HI:`CFG_PTR_LO] <= time_window_pointer - 2'b01;
         end
         if (wr_cfg && wr_lo) begin
            cfg_reg[`CFG_CAL_HI:0] <= reg_wdata[`CFG_CAL_HI:0];
         end
      end
   end

   // Pad configuration
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pad_reg <= `PAD_RESET;
      end else if (wr_pad && wr_lo) begin
         pad_reg <= reg_wdata[1:0];
      end
   end

   // Calendar counters; a software write wins over a rollover in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sec_reg <= `BCD_00;
         min_reg <= `BCD_00;
         hr_reg <= `BCD_00;
         wd_reg <= `BCD_00;
         day_reg <= `BCD_01;
         mth_reg <= `BCD_01;
         yr_reg <= `BCD_00;
      end else if (time_wr_ok) begin
         case (time_window_pointer)
            WIN_SEC_MIN: begin
               if (wr_hi) begin
                  min_reg <= reg_wdata[15:8] & `MASK_MIN;
               end
               if (wr_lo) begin
                  sec_reg <= reg_wdata[7:0] & `MASK_SEC;
               end
            end
            WIN_HOUR_WDAY: begin
               if (wr_hi) begin
                  wd_reg <= reg_wdata[15:8] & `MASK_WDAY;
               end
               if (wr_lo) begin
                  hr_reg <= reg_wdata[7:0] & `MASK_HOUR;
               end
            end
            WIN_DAY_MONTH: begin
               if (wr_hi) begin
                  mth_reg <= reg_wdata[15:8] & `MASK_MONTH;
               end
               if (wr_lo) begin
                  day_reg <= reg_wdata[7:0] & `MASK_DAY;
               end
            end
            default: begin
               if (wr_lo) begin
                  yr_reg <= reg_wdata[7:0] & `MASK_YEAR;
               end
            end
         endcase
      end else begin
         if (sec_tick) begin
            sec_reg <= bcd_step(sec_reg, `BCD_59, `BCD_00);
         end
         if (min_end) begin
            min_reg <= bcd_step(min_reg, `BCD_59, `BCD_00);
         end
         if (hr_end) begin
            hr_reg <= bcd_step(hr_reg, `BCD_23, `BCD_00);
         end
         if (day_end) begin
            wd_reg <= bcd_step(wd_reg, `WDAY_LAST, `BCD_00);
            day_reg <= bcd_step(day_reg, month_last(mth_reg, yr_reg), `BCD_01);
         end
         if (mth_end) begin
            mth_reg <= bcd_step(mth_reg, `BCD_12, `BCD_01);
         end
         if (yr_end) begin
            yr_reg <= bcd_step(yr_reg, `BCD_99, `BCD_00);
         end
      end
   end

   // Alarm value pairs, pointer 11 has no storage behind it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         asec_reg <= `BCD_00;
         amin_reg <= `BCD_00;
         ahr_reg <= `BCD_00;
         awd_reg <= `BCD_00;
         aday_reg <= `BCD_01;
         amth_reg <= `BCD_01;
      end else if (wr_alarm) begin
         case (alarm_window_pointer)
            WIN_SEC_MIN: begin
               if (wr_hi) begin
                  amin_reg <= reg_wdata[15:8] & `MASK_MIN;
               end
               if (wr_lo) begin
                  asec_reg <= reg_wdata[7:0] & `MASK_SEC;
               end
            end
            WIN_HOUR_WDAY: begin
               if (wr_hi) begin
                  awd_reg <= reg_wdata[15:8] & `MASK_WDAY;
               end
               if (wr_lo) begin
                  ahr_reg <= reg_wdata[7:0] & `MASK_HOUR;
               end
            end
            WIN_DAY_MONTH: begin
               if (wr_hi) begin
                  amth_reg <= reg_wdata[15:8] & `MASK_MONTH;
               end
               if (wr_lo) begin
                  aday_reg <= reg_wdata[7:0] & `MASK_DAY;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Digit match for the chosen interval; reserved codes never match
   logic match, fire;
   logic m_sec1, m_sec, m_min1, m_min, m_hr, m_wd, m_day, m_mth;
   assign m_sec1 = sec_reg[3:0] == asec_reg[3:0];
   assign m_sec = sec_reg == asec_reg;
   assign m_min1 = min_reg[3:0] == amin_reg[3:0];
   assign m_min = min_reg == amin_reg;
   assign m_hr = hr_reg == ahr_reg;
   assign m_wd = wd_reg == awd_reg;
   assign m_day = day_reg == aday_reg;
   assign m_mth = mth_reg == amth_reg;

   always_comb begin
      case (alarm_interval_code)
         INT_HALF_SEC: match = half_tick;
         INT_SEC: match = sec_tick;
         INT_TEN_SEC: match = sec_tick && m_sec1;
         INT_MINUTE: match = sec_tick && m_sec;
         INT_TEN_MIN: match = sec_tick && m_sec && m_min1;
         INT_HOUR: match = sec_tick && m_sec && m_min;
         INT_DAY: match = sec_tick && m_sec && m_min && m_hr;
         INT_WEEK: match = sec_tick && m_sec && m_min && m_hr && m_wd;
         INT_MONTH: match = sec_tick && m_sec && m_min && m_hr && m_day;
         // Feb 29 only exists in leap years, so it matches every fourth year
         INT_YEAR: match = sec_tick && m_sec && m_min && m_hr && m_day && m_mth;
         default: match = 1'b0;
      endcase
   end

   // Compared on the value before the tick lands, i.e. at the end of the matched second
   assign fire = alarm_on && match;

   // Alarm configuration, repeat counting and self-disable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         alm_cfg_reg <= `ALARM_CFG_RESET;
      end else begin
         if (wr_alm_cfg && wr_hi) begin
            alm_cfg_reg[15:8] <= reg_wdata[15:8];
         end else if ((rd_alarm || (wr_alarm && wr_hi)) && alarm_window_pointer != 2'b00) begin
            alm_cfg_reg[`ALM_PTR_HI:`ALM_PTR_LO] <= alarm_window_pointer - 2'b01;
         end
         // Self-disable is kept apart so a pointer step in the same cycle cannot swallow it
         if (!(wr_alm_cfg && wr_hi) && fire && alarm_repeat_count == `RPT_EMPTY && !chime) begin
            alm_cfg_reg[`ALM_ON] <= 1'b0;
         end
         if (wr_alm_cfg && wr_lo) begin
            alm_cfg_reg[`ALM_RPT_HI:0] <= reg_wdata[7:0];
         end else if (fire) begin
            if (alarm_repeat_count != `RPT_EMPTY) begin
               alm_cfg_reg[`ALM_RPT_HI:0] <= alarm_repeat_count - 8'h01;
            end else if (chime) begin
               alm_cfg_reg[`ALM_RPT_HI:0] <= `RPT_FULL;
            end
         end
      end
   end

   // Alarm pulse toggles per event, so it runs at half the alarm rate
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         alm_pulse_reg <= 1'b0;
         alarm_event <= 1'b0;
      end else begin
         alm_pulse_reg <= alm_pulse_reg ^ fire;
         alarm_event <= fire;
      end
   end

   // Output pin; seconds clock is high in the first half of each second
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clock_pin_out <= 1'b0;
         clock_pin_oe <= 1'b0;
      end else begin
         clock_pin_oe <= clock_pin_drive_on;
         clock_pin_out <= clock_pin_drive_on &&
            (pin_source_select ? !half_second_flag : alm_pulse_reg);
      end
   end

   // Read mux; window reads show the pair before the pointer steps
   always_comb begin
      rdata_next = 16'h0000;
      case (reg_addr)
         `OFS_CAL_CONFIG: begin
            rdata_next = cfg_reg;
            rdata_next[14] = 1'b0;
            rdata_next[`CFG_SYNC] = presc_reg >= $signed(`PRESC_SYNC);
            rdata_next[`CFG_HALF] = half_second_flag;
         end
         `OFS_PAD_CONFIG: rdata_next = {14'h0000, pad_reg};
         `OFS_ALARM_CFG: rdata_next = alm_cfg_reg;
         `OFS_TIME_WIN: begin
            case (time_window_pointer)
               WIN_SEC_MIN: rdata_next = {min_reg, sec_reg};
               WIN_HOUR_WDAY: rdata_next = {wd_reg, hr_reg};
               WIN_DAY_MONTH: rdata_next = {mth_reg, day_reg};
               default: rdata_next = {8'h00, yr_reg};
            endcase
         end
         `OFS_ALARM_WIN: begin
            case (alarm_window_pointer)
               WIN_SEC_MIN: rdata_next = {amin_reg, asec_reg};
               WIN_HOUR_WDAY: rdata_next = {awd_reg, ahr_reg};
               WIN_DAY_MONTH: rdata_next = {amth_reg, aday_reg};
               default: rdata_next = 16'h0000;
            endcase
         end
         default: rdata_next = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rdata_next : 16'h0000;
      end
   end
endmodule

// >>> dv/rtc_calendar_alarm_regs_props.sv
// Port checker for the clock calendar unit
`timescale 1ns/10ps
`include "rtc_calendar_params.svh"
module rtc_calendar_alarm_regs_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic por,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [1:0] reg_byte_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic clock_pin_out,
   input wire logic clock_pin_oe,
   input wire logic alarm_event
);
   // Power-on reset clears the config word, so it masks checks as well
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst || por);
   logic cfg_hi_wr;
   // High byte of the config word written in this cycle
   assign cfg_hi_wr = reg_wr && reg_addr == `OFS_CAL_CONFIG && reg_byte_en[1];
   // Properties
   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   property p_event_pulse;
      alarm_event |=> !alarm_event;
   endproperty
   property p_pin_drive;
      clock_pin_out |-> clock_pin_oe;
   endproperty
   property p_oe_follow;
      cfg_hi_wr |=> ##1 clock_pin_oe == $past(reg_wdata[`CFG_DRIVE_ON], 2);
   endproperty
   property p_oe_hold;
      !cfg_hi_wr |=> ##1 $stable(clock_pin_oe);
   endproperty
   property p_unmapped;
      reg_rd && reg_addr > `OFS_ALARM_WIN |=> reg_rdata == 16'h0000;
   endproperty
   property p_pad_unused;
      reg_rd && reg_addr == `OFS_PAD_CONFIG |=> reg_rdata[15:2] == 14'h0000;
   endproperty
   property p_time_top;
      reg_rd && reg_addr == `OFS_TIME_WIN |=> reg_rdata[15] == 1'b0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read");
   a_event_pulse: assert property (p_event_pulse)
      else $error("alarm event longer than one cycle");
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin high while not driven");
   a_oe_follow: assert property (p_oe_follow)
      else $error("pin enable does not follow config write");
   a_oe_hold: assert property (p_oe_hold)
      else $error("pin enable changed without config write");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_pad_unused: assert property (p_pad_unused)
      else $error("pad unused bits not zero");
   a_time_top: assert property (p_time_top)
      else $error("time window bit 15 not zero");
   // Main scenarios
   c_event: cover property (alarm_event);
   c_oe: cover property ($rose(clock_pin_oe));
   c_time_read: cover property (reg_rd && reg_addr == `OFS_TIME_WIN);
endmodule

bind rtc_calendar_alarm_regs rtc_calendar_alarm_regs_props u_rtc_calendar_alarm_regs_props (
   .ref_clk, .rst, .por, .reg_addr, .reg_wdata, .reg_byte_en, .reg_wr, .reg_rd,
   .reg_rdata, .clock_pin_out, .clock_pin_oe, .alarm_event);

// >>> dv/tb_top.sv
// Self-checking bench for the clock calendar unit
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic wr; logic [3:0] a; logic [1:0] be; logic [15:0] d;} op_t;
   logic ref_clk, rst, por, sosc_tick, reg_wr, reg_rd;
   logic clock_pin_out, clock_pin_oe, alarm_event, parallel_port_buffer_select;
   logic [3:0] reg_addr;
   logic [1:0] reg_byte_en;
   logic [15:0] reg_wdata, reg_rdata, seen;
   int errors, tests_run, n;
   // Writes set up state; reads carry the expected word
   op_t ops [33] = '{'{1,4'h2,3,16'hFFFF}, '{0,4'h2,3,16'h0003},
      '{1,4'h0,3,16'h8000}, '{0,4'h0,3,16'h0000}, '{1,4'h0,3,16'h2381},
      '{1,4'h0,3,16'hA381}, '{0,4'h0,3,16'hA381}, '{1,4'h6,1,16'h0099},
      '{0,4'h6,3,16'h0099}, '{1,4'h6,3,16'h1231}, '{1,4'h6,3,16'h0623},
      '{1,4'h6,3,16'h5959}, '{0,4'h6,3,16'h5959}, '{1,4'h0,3,16'hA2FF},
      '{0,4'h6,3,16'h1231}, '{0,4'h6,3,16'h0623}, '{0,4'h0,3,16'hA0FF},
      '{1,4'h0,3,16'h8100}, '{1,4'h6,3,16'h0111}, '{0,4'h0,3,16'h8000},
      '{1,4'h0,3,16'h8100}, '{0,4'h6,3,16'h0623}, '{1,4'h4,3,16'h0200},
      '{1,4'h8,3,16'h1231}, '{1,4'h8,3,16'h0623}, '{0,4'h4,3,16'h0000},
      '{1,4'h8,3,16'h0000}, '{0,4'h4,3,16'h0000}, '{1,4'h4,3,16'h0300},
      '{0,4'h8,3,16'h0000}, '{0,4'h8,3,16'h1231}, '{0,4'h4,3,16'h0100},
      '{0,4'hA,3,16'h0000}};

   rtc_calendar_alarm_regs u_rtc_calendar_alarm_regs (.ref_clk, .rst, .por, .sosc_tick,
      .reg_addr, .reg_wdata, .reg_byte_en, .reg_wr, .reg_rd, .reg_rdata, .clock_pin_out,
      .clock_pin_oe, .alarm_event, .parallel_port_buffer_select);

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask

   // One strobe cycle, then idle; read data are taken in the cycle after
   task automatic op(input logic w, input logic [3:0] a, input logic [1:0] be,
                     input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_byte_en <= be;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      seen = reg_rdata;
   endtask

   task automatic results();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Half a second of oscillator ticks is some 16k cycles, so the bound is generous
   task automatic wait_event();
      n = 0;
      while (alarm_event !== 1'b1 && n < 40000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 40000) begin
         errors++;
         results();
      end
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   // Main sequence
   initial begin
      errors = 0;
      tests_run = 0;
      rst = 1'b1;
      por = 1'b1;
      sosc_tick = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_byte_en = 2'h0;
      reg_wdata = 16'h0000;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      por <= 1'b0;
      foreach (ops[i]) begin
         op(ops[i].wr, ops[i].a, ops[i].be, ops[i].d);
         if (!ops[i].wr) check(seen, ops[i].d);
      end
      // Interval codes 0000 to 1001 are each stored as written
      for (int i = 0; i < 10; i++) begin
         op(1'b1, 4'h4, 2'h3, {2'h0, i[3:0], 10'h000});
         op(1'b0, 4'h4, 2'h3, 16'h0000);
         check(seen, {2'h0, i[3:0], 10'h000});
      end
      // Alarm pulse on the pin; the empty repeat count wraps while chime is on
      op(1'b1, 4'h2, 2'h3, 16'h0001);
      op(1'b1, 4'h0, 2'h3, 16'h847F);
      repeat (2) @(posedge ref_clk);
      #1;
      check({14'h0, clock_pin_oe, clock_pin_out}, 16'h0002);
      check({15'h0, parallel_port_buffer_select}, 16'h0001);
      op(1'b1, 4'h4, 2'h3, 16'hC000);
      @(posedge ref_clk);
      sosc_tick <= 1'b1;
      wait_event();
      check({15'h0, clock_pin_out}, 16'h0001);
      op(1'b0, 4'h4, 2'h3, 16'h0000);
      check(seen, 16'hC0FF);
      // Without chime the last event turns the alarm off
      op(1'b1, 4'h4, 2'h3, 16'h8000);
      wait_event();
      check({15'h0, clock_pin_out}, 16'h0000);
      op(1'b0, 4'h4, 2'h3, 16'h0000);
      check(seen, 16'h0000);
      // Second 59 ended above, so trim +127 restarted the prescaler at 508: half flag comes early
      repeat (16100) @(posedge ref_clk);
      op(1'b0, 4'h0, 2'h3, 16'h0000);
      check(seen, 16'h8C7F);
      @(posedge ref_clk);
      sosc_tick <= 1'b0;
      // Plain reset keeps the config word, power-on reset clears it
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      op(1'b0, 4'h0, 2'h3, 16'h0000);
      check(seen, 16'h847F);
      op(1'b0, 4'h2, 2'h3, 16'h0000);
      check(seen, 16'h0000);
      @(posedge ref_clk);
      por <= 1'b1;
      repeat (2) @(posedge ref_clk);
      por <= 1'b0;
      op(1'b0, 4'h0, 2'h3, 16'h0000);
      check(seen, 16'h0000);
      results();
   end
endmodule
